// file: hw/gfsu_pkg.sv
// Constants, pin function codes and slot signal bundle for the pin 3/4 function select block
package gfsu_pkg;
  // Configuration space byte offset of the pin function select register
  localparam logic [11:0] GFSU_CTL_OFFSET = 12'h0bc;
  localparam logic [15:0] GFSU_CTL_RESET = 16'h0000;
  // Bit 15 is reserved and never stored
  localparam logic [15:0] GFSU_CTL_WMASK = 16'h7fff;
  localparam int GFSU_RSVD_BIT = 15;
  localparam int GFSU_P4_MSB = 14;
  localparam int GFSU_P4_LSB = 12;
  localparam int GFSU_P3_MSB = 11;
  localparam int GFSU_P3_LSB = 9;

  typedef enum logic [2:0] {
    P4_GP_IN = 3'b000,
    P4_GP_OUT = 3'b001,
    P4_P1_ATTN_BTN = 3'b010,
    P4_P3_ATTN_BTN = 3'b011,
    P4_P1_PWR_FAULT = 3'b100,
    P4_P3_PWR_FAULT = 3'b101,
    P4_P1_INTERLOCK = 3'b110,
    P4_P3_INTERLOCK = 3'b111
  } gfsu_pin4_fn_t;

  typedef enum logic [2:0] {
    P3_GP_IN = 3'b000,
    P3_GP_OUT = 3'b001,
    P3_P1_CLK_REQ = 3'b010,
    P3_P1_LATCH = 3'b011,
    P3_P2_PWR_FAULT = 3'b100,
    P3_P3_PWR_FAULT = 3'b101,
    P3_P2_LATCH = 3'b110,
    P3_P3_LATCH = 3'b111
  } gfsu_pin3_fn_t;

  // Pin levels handed to the hot-plug logic of ports 1 to 3
  typedef struct packed {
    logic port1_attention_button;
    logic port3_attention_button;
    logic port1_power_fault;
    logic port2_power_fault;
    logic port3_power_fault;
    logic port1_interlock_engage;
    logic port3_interlock_engage;
    logic port1_clock_request;
    logic port1_latch_sensor;
    logic port2_latch_sensor;
    logic port3_latch_sensor;
    logic port3_presence_detect;
  } gfsu_slot_t;
endpackage

// file: hw/gfsu_top.sv
// Pin function select for general-purpose pins 3 and 4 with hot-plug routing
module gfsu_top
  import gfsu_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic eeprom_load,
  input wire logic [15:0] eeprom_data,
  input wire logic second_downstream_strap,
  input wire logic gpio3_pin_in,
  output logic gpio3_pin_out,
  output logic gpio3_pin_oe,
  input wire logic gpio4_pin_in,
  output logic gpio4_pin_out,
  output logic gpio4_pin_oe,
  input wire logic gpio3_out_data,
  input wire logic gpio4_out_data,
  output logic gpio3_in_data,
  output logic gpio4_in_data,
  output logic pin4_strapped,
  output gfsu_slot_t slot_out
);

  function automatic logic fn_hit(logic [2:0] sel, logic [2:0] code, logic lvl);
    fn_hit = (sel == code) && lvl;
  endfunction

  logic [15:0] ctl_reg;
  logic [15:0] ctl_next;
  logic [15:0] ctl_wr_val;
  logic ctl_hit;
  logic rd_hit;
  logic [2:0] p3_s_reg;
  logic [2:0] p4_s_reg;
  logic [2:0] st_s_reg;
  logic p3_filt_reg;
  logic p4_filt_reg;
  logic st_filt_reg;
  logic strap_done_reg;
  logic strap_reg;
  gfsu_pin4_fn_t pin4_function_select;
  gfsu_pin3_fn_t pin3_function_select;
  logic p4_free;
  gfsu_slot_t slot_next;

  // Configuration write with byte enables; EEPROM preload takes priority
  assign ctl_hit = cfg_wr && (cfg_addr == GFSU_CTL_OFFSET);
  assign rd_hit = cfg_rd && (cfg_addr == GFSU_CTL_OFFSET);
  assign ctl_wr_val = {cfg_be[1] ? cfg_wdata[15:8] : ctl_reg[15:8],
                       cfg_be[0] ? cfg_wdata[7:0] : ctl_reg[7:0]};
  assign ctl_next = (eeprom_load ? eeprom_data : ctl_hit ? ctl_wr_val : ctl_reg)
                    & GFSU_CTL_WMASK;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctl_reg <= GFSU_CTL_RESET;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // Bits 8:0 are held for the lower pins and do not steer this block
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cfg_rvalid <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_rvalid <= cfg_rd;
      cfg_rdata <= rd_hit ? {16'h0000, ctl_reg & GFSU_CTL_WMASK} : 32'h0000_0000;
    end
  end

  // Pin synchronisers: a level counts once stages two and three agree
  always_ff @(posedge clock) begin
    if (!resetn) begin
      p3_s_reg <= 3'b000;
      p4_s_reg <= 3'b000;
      p3_filt_reg <= 1'b0;
      p4_filt_reg <= 1'b0;
    end else begin
      p3_s_reg <= {p3_s_reg[1:0], gpio3_pin_in};
      p4_s_reg <= {p4_s_reg[1:0], gpio4_pin_in};
      if (p3_s_reg[1] == p3_s_reg[2]) begin
        p3_filt_reg <= p3_s_reg[2];
      end
      if (p4_s_reg[1] == p4_s_reg[2]) begin
        p4_filt_reg <= p4_s_reg[2];
      end
    end
  end

  // Strap chain keeps running through reset so it is settled at release
  always_ff @(posedge clock) begin
    st_s_reg <= {st_s_reg[1:0], second_downstream_strap};
    if (st_s_reg[1] == st_s_reg[2]) begin
      st_filt_reg <= st_s_reg[2];
    end
  end

  // Strap is caught once, on the first edge after reset release
  always_ff @(posedge clock) begin
    if (!resetn) begin
      strap_done_reg <= 1'b0;
      strap_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      strap_reg <= st_filt_reg;
    end
  end

  assign pin4_function_select = gfsu_pin4_fn_t'(ctl_reg[GFSU_P4_MSB:GFSU_P4_LSB]);
  assign pin3_function_select = gfsu_pin3_fn_t'(ctl_reg[GFSU_P3_MSB:GFSU_P3_LSB]);
  // A strapped pin 4 ignores its select field entirely
  assign p4_free = !strap_reg;

  // Slot routing; unselected slot signals rest at zero
  assign slot_next.port1_attention_button =
    p4_free && fn_hit(pin4_function_select, P4_P1_ATTN_BTN, p4_filt_reg);
  assign slot_next.port3_attention_button =
    p4_free && fn_hit(pin4_function_select, P4_P3_ATTN_BTN, p4_filt_reg);
  assign slot_next.port1_power_fault =
    p4_free && fn_hit(pin4_function_select, P4_P1_PWR_FAULT, p4_filt_reg);
  assign slot_next.port1_interlock_engage =
    p4_free && fn_hit(pin4_function_select, P4_P1_INTERLOCK, p4_filt_reg);
  assign slot_next.port3_interlock_engage =
    p4_free && fn_hit(pin4_function_select, P4_P3_INTERLOCK, p4_filt_reg);
  // Port 3 power fault may come from either pin
  assign slot_next.port3_power_fault =
    (p4_free && fn_hit(pin4_function_select, P4_P3_PWR_FAULT, p4_filt_reg))
    || fn_hit(pin3_function_select, P3_P3_PWR_FAULT, p3_filt_reg);
  assign slot_next.port1_clock_request =
    fn_hit(pin3_function_select, P3_P1_CLK_REQ, p3_filt_reg);
  assign slot_next.port1_latch_sensor =
    fn_hit(pin3_function_select, P3_P1_LATCH, p3_filt_reg);
  assign slot_next.port2_power_fault =
    fn_hit(pin3_function_select, P3_P2_PWR_FAULT, p3_filt_reg);
  assign slot_next.port2_latch_sensor =
    fn_hit(pin3_function_select, P3_P2_LATCH, p3_filt_reg);
  assign slot_next.port3_latch_sensor =
    fn_hit(pin3_function_select, P3_P3_LATCH, p3_filt_reg);
  assign slot_next.port3_presence_detect = strap_reg && p4_filt_reg;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      slot_out <= '0;
      gpio3_in_data <= 1'b0;
      gpio4_in_data <= 1'b0;
      gpio3_pin_out <= 1'b0;
      gpio3_pin_oe <= 1'b0;
      gpio4_pin_out <= 1'b0;
      gpio4_pin_oe <= 1'b0;
      pin4_strapped <= 1'b0;
    end else begin
      slot_out <= slot_next;
      // General input path only when the pin is a general pin
      gpio3_in_data <= (pin3_function_select == P3_GP_IN) && p3_filt_reg;
      gpio4_in_data <= p4_free && (pin4_function_select == P4_GP_IN) && p4_filt_reg;
      gpio3_pin_out <= (pin3_function_select == P3_GP_OUT) && gpio3_out_data;
      gpio3_pin_oe <= pin3_function_select == P3_GP_OUT;
      gpio4_pin_out <= p4_free && (pin4_function_select == P4_GP_OUT) && gpio4_out_data;
      gpio4_pin_oe <= p4_free && (pin4_function_select == P4_GP_OUT);
      pin4_strapped <= strap_reg;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_reset_zero;
    $past(!resetn) |-> (ctl_reg == GFSU_CTL_RESET) && !gpio3_pin_oe && !gpio4_pin_oe;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("register or drive not clear after reset");

  property p_rsvd_zero;
    cfg_rvalid |-> !cfg_rdata[GFSU_RSVD_BIT] && (cfg_rdata[31:16] == 16'h0000);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits read nonzero");

  property p_readback;
    (cfg_rd && cfg_addr == GFSU_CTL_OFFSET && !$past(!resetn)) |=> cfg_rvalid
      && (cfg_rdata[14:0] == $past(ctl_reg[14:0]));
  endproperty
  a_readback: assert property (p_readback)
    else $error("read of select register returned wrong data");

  property p_pin4_out;
    (!strap_reg && ctl_reg[GFSU_P4_MSB:GFSU_P4_LSB] == P4_GP_OUT) |=> gpio4_pin_oe;
  endproperty
  a_pin4_out: assert property (p_pin4_out)
    else $error("pin 4 not driven in general output role");

  property p_pin4_attn;
    (!strap_reg && ctl_reg[GFSU_P4_MSB:GFSU_P4_LSB] == P4_P1_ATTN_BTN) ##0 (p4_filt_reg == 1'b1)
      |=> slot_out.port1_attention_button && !gpio4_in_data;
  endproperty
  a_pin4_attn: assert property (p_pin4_attn)
    else $error("pin 4 attention button not routed");

  property p_eeprom;
    eeprom_load |=> ctl_reg[GFSU_P4_MSB:GFSU_P3_LSB]
      == $past(eeprom_data[GFSU_P4_MSB:GFSU_P3_LSB]);
  endproperty
  a_eeprom: assert property (p_eeprom)
    else $error("EEPROM preload not taken");

  property p_strap;
    strap_reg |=> !gpio4_pin_oe && !gpio4_in_data && !slot_out.port1_power_fault;
  endproperty
  a_strap: assert property (p_strap)
    else $error("strapped pin 4 still used as general pin");

  property p_pin3_out;
    (ctl_reg[GFSU_P3_MSB:GFSU_P3_LSB] != P3_GP_OUT) |=> !gpio3_pin_oe
      ##1 (gpio3_pin_oe == $past(ctl_reg[GFSU_P3_MSB:GFSU_P3_LSB] == P3_GP_OUT));
  endproperty
  a_pin3_out: assert property (p_pin3_out)
    else $error("pin 3 drive does not follow its select field");

  property p_pin3_pfault;
    (ctl_reg[GFSU_P3_MSB:GFSU_P3_LSB] == P3_P2_PWR_FAULT && p3_filt_reg)
      |=> slot_out.port2_power_fault;
  endproperty
  a_pin3_pfault: assert property (p_pin3_pfault)
    else $error("pin 3 port 2 power fault not routed");

  property p_slot_bypass;
    (ctl_reg[GFSU_P3_MSB:GFSU_P3_LSB] > P3_GP_OUT) |=> !gpio3_in_data && !gpio3_pin_oe;
  endproperty
  a_slot_bypass: assert property (p_slot_bypass)
    else $error("general path active while pin 3 in slot role");

  c_strap: cover property (strap_reg && p4_filt_reg ##1 slot_out.port3_presence_detect);
  c_pin4_gpo: cover property (
    ctl_hit && cfg_wdata[GFSU_P4_MSB:GFSU_P4_LSB] == P4_GP_OUT ##2 gpio4_pin_oe);
  c_pin3_latch: cover property (
    ctl_reg[GFSU_P3_MSB:GFSU_P3_LSB] == P3_P3_LATCH ##1 slot_out.port3_latch_sensor);
  c_eeprom: cover property (eeprom_load ##1 ctl_reg != GFSU_CTL_RESET);

endmodule

// file: testbench/gfsu_slot_model.sv
// Behavioural slot side: buttons, sensors and strap that drive pins 3 and 4
module gfsu_slot_model (
  input wire logic level3,
  input wire logic level4,
  input wire logic strap_level,
  input wire logic gpio3_pin_out,
  input wire logic gpio3_pin_oe,
  input wire logic gpio4_pin_out,
  input wire logic gpio4_pin_oe,
  output logic gpio3_pin_in,
  output logic gpio4_pin_in,
  output logic second_downstream_strap
);
  timeunit 1ns;
  timeprecision 100ps;
  // Wire level: the switch wins only while it drives the pin
  assign gpio3_pin_in = gpio3_pin_oe ? gpio3_pin_out : level3;
  assign gpio4_pin_in = gpio4_pin_oe ? gpio4_pin_out : level4;
  assign second_downstream_strap = strap_level;
endmodule

// file: testbench/gfsu_top_tb.sv
// Self-checking bench for the pin 3/4 function select block
module gfsu_top_tb
  import gfsu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0;
  logic resetn = 0;
  logic cfg_wr = 0;
  logic cfg_rd = 0;
  logic [11:0] cfg_addr = '0;
  logic [3:0] cfg_be = '0;
  logic [31:0] cfg_wdata = '0;
  logic [31:0] cfg_rdata;
  logic cfg_rvalid;
  logic eeprom_load = 0;
  logic [15:0] eeprom_data = '0;
  logic strap_level = 0;
  logic level3 = 0;
  logic level4 = 0;
  logic second_downstream_strap, gpio3_pin_in, gpio4_pin_in;
  logic gpio3_pin_out, gpio3_pin_oe, gpio4_pin_out, gpio4_pin_oe;
  logic gpio3_out_data = 0;
  logic gpio4_out_data = 0;
  logic gpio3_in_data, gpio4_in_data, pin4_strapped;
  gfsu_slot_t slot_out, exp_slot;
  int miscompares = 0;
  int check_count = 0;

  gfsu_top i_gfsu_top (.clock(clock), .resetn(resetn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .eeprom_load(eeprom_load), .eeprom_data(eeprom_data),
    .second_downstream_strap(second_downstream_strap), .gpio3_pin_in(gpio3_pin_in),
    .gpio3_pin_out(gpio3_pin_out), .gpio3_pin_oe(gpio3_pin_oe), .gpio4_pin_in(gpio4_pin_in),
    .gpio4_pin_out(gpio4_pin_out), .gpio4_pin_oe(gpio4_pin_oe),
    .gpio3_out_data(gpio3_out_data), .gpio4_out_data(gpio4_out_data),
    .gpio3_in_data(gpio3_in_data), .gpio4_in_data(gpio4_in_data),
    .pin4_strapped(pin4_strapped), .slot_out(slot_out));

  gfsu_slot_model i_gfsu_slot_model (.level3(level3), .level4(level4),
    .strap_level(strap_level), .gpio3_pin_out(gpio3_pin_out), .gpio3_pin_oe(gpio3_pin_oe),
    .gpio4_pin_out(gpio4_pin_out), .gpio4_pin_oe(gpio4_pin_oe), .gpio3_pin_in(gpio3_pin_in),
    .gpio4_pin_in(gpio4_pin_in), .second_downstream_strap(second_downstream_strap));

  always #2 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic do_reset(input logic strap);
    @(posedge clock);
    resetn <= 1'b0;
    strap_level <= strap;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic cfg_write(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clock);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_wr <= 1'b0;
  endtask

  task automatic cfg_read(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clock);
    cfg_rd <= 1'b0;
    #1;
    check(32'(cfg_rvalid), 32'h0000_0001);
    check(cfg_rdata, exp);
  endtask

  function automatic gfsu_slot_t slot_for(input bit pin4, input logic [2:0] code);
    gfsu_slot_t s;
    s = '0;
    if (pin4) begin
      case (code)
        P4_P1_ATTN_BTN: s.port1_attention_button = 1'b1;
        P4_P3_ATTN_BTN: s.port3_attention_button = 1'b1;
        P4_P1_PWR_FAULT: s.port1_power_fault = 1'b1;
        P4_P3_PWR_FAULT: s.port3_power_fault = 1'b1;
        P4_P1_INTERLOCK: s.port1_interlock_engage = 1'b1;
        P4_P3_INTERLOCK: s.port3_interlock_engage = 1'b1;
        default: s = '0;
      endcase
    end else begin
      case (code)
        P3_P1_CLK_REQ: s.port1_clock_request = 1'b1;
        P3_P1_LATCH: s.port1_latch_sensor = 1'b1;
        P3_P2_PWR_FAULT: s.port2_power_fault = 1'b1;
        P3_P3_PWR_FAULT: s.port3_power_fault = 1'b1;
        P3_P2_LATCH: s.port2_latch_sensor = 1'b1;
        P3_P3_LATCH: s.port3_latch_sensor = 1'b1;
        default: s = '0;
      endcase
    end
    return s;
  endfunction

  // Every code of one pin, with that pin high and the other pin low
  task automatic pin_test(input bit pin4);
    logic [2:0] code;
    for (int c = 0; c < 8; c++) begin
      code = 3'(c);
      cfg_write(12'h0bc, 4'b0011, pin4 ? {17'h0_0000, code, 12'h000} : {20'h0_0000, code, 9'h000});
      level4 <= pin4;
      level3 <= !pin4;
      gpio4_out_data <= pin4;
      gpio3_out_data <= !pin4;
      repeat (8) @(posedge clock);
      #1;
      check(32'(slot_out), 32'(slot_for(pin4, code)));
      check(32'(pin4 ? gpio4_in_data : gpio3_in_data), 32'(code == 3'b000));
      check(32'(pin4 ? gpio4_pin_oe : gpio3_pin_oe), 32'(code == 3'b001));
      check(32'(pin4 ? gpio4_pin_out : gpio3_pin_out), 32'(code == 3'b001));
      // The driven level must follow the data input, not just the enable
      if (code == 3'b001) begin
        gpio4_out_data <= 1'b0;
        gpio3_out_data <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check(32'(pin4 ? gpio4_pin_out : gpio3_pin_out), 32'h0000_0000);
      end
    end
    $display("test pin roles done");
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    close_out();
  end

  initial begin
    do_reset(1'b0);
    cfg_read(12'h0bc, 32'h0000_0000);
    check(32'(pin4_strapped), 32'h0000_0000);
    cfg_write(12'h0bc, 4'b0011, 32'hffff_ffff);
    cfg_read(12'h0bc, 32'h0000_7fff);
    cfg_write(12'h0bc, 4'b0001, 32'h0000_0000);
    cfg_write(12'h0c0, 4'b1111, 32'h0000_0000);
    cfg_read(12'h0bc, 32'h0000_7f00);
    cfg_read(12'h0b8, 32'h0000_0000);
    $display("test register access done");
    pin_test(1'b1);
    pin_test(1'b0);
    @(posedge clock);
    eeprom_load <= 1'b1;
    eeprom_data <= 16'haa00;
    cfg_wr <= 1'b1;
    cfg_addr <= 12'h0bc;
    cfg_wdata <= 32'h0000_0000;
    @(posedge clock);
    eeprom_load <= 1'b0;
    cfg_wr <= 1'b0;
    cfg_read(12'h0bc, 32'h0000_2a00);
    do_reset(1'b0);
    cfg_read(12'h0bc, 32'h0000_0000);
    $display("test eeprom and reset done");
    do_reset(1'b1);
    check(32'(pin4_strapped), 32'h0000_0001);
    // Field written anyway to show it is ignored while strapped
    cfg_write(12'h0bc, 4'b0011, 32'h0000_1000);
    level4 <= 1'b1;
    repeat (8) @(posedge clock);
    #1;
    exp_slot = '0;
    exp_slot.port3_presence_detect = 1'b1;
    check(32'(slot_out), 32'(exp_slot));
    check(32'(gpio4_pin_oe), 32'h0000_0000);
    check(32'(gpio4_in_data), 32'h0000_0000);
    // Software puts the ignored field back to its default
    cfg_write(12'h0bc, 4'b0011, 32'h0000_0000);
    cfg_read(12'h0bc, 32'h0000_0000);
    do_reset(1'b0);
    check(32'(pin4_strapped), 32'h0000_0000);
    $display("test strap done");
    close_out();
  end
endmodule
